// [mct_timer.sv]
// Multi-channel timer: shared counter, per-channel compare/PWM/capture, APB slave
// Notes on behaviour
// RQ1: The counter and outputs keep running whenever the block is enabled, regardless of processor halt.
// RQ2: While stop mode is asserted all timer activity freezes as if the clock had stopped.
// RQ3: Stop mode resets nothing, so counting resumes from the held state afterwards.
// RQ4: A cleared block enable stops all counter and channel activity.
// RQ5: A cleared channel enable stops only that channel's private logic.
// RQ6: Register reads and writes complete normally whatever the enables hold.
// RQ7: Each channel has an 8-bit control register resetting to zero with enable, polarity, interrupt, aux and method fields.
// RQ8: In one-shot and continuous compare a disabled channel drives its polarity level.
// RQ9: In one-shot an enabled channel inverts its output for exactly one cycle on compare match.
// RQ10: In continuous compare an enabled channel toggles and holds its output on each compare match.
// RQ11: In PWM a disabled channel drives low whatever its polarity.
// RQ12: In PWM an enabled channel goes high on match and low at reload (modulo) or when counting down through compare.
// RQ13: In capture the count is latched on a rising input edge with polarity 0, falling edge with polarity 1.
// RQ14: Up/down counting lets two channels with offset compares form complementary PWM with dead time.
// RQ15: Method codes are 0 one-shot, 1 continuous compare, 2 PWM, 3 capture, others idle.
// RQ16: Control bit 3 reads zero and ignores writes.
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "mct_map.svh"

module mct_timer (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_STOP,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`MCT_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic [`MCT_NUM_CH-1:0] I_CH_IN,
  output logic [`MCT_NUM_CH-1:0] O_CH_OUT
);

  // Byte address of one channel register
  function automatic logic [`MCT_ADDR_W-1:0] ch_addr(input int ch, input logic [`MCT_ADDR_W-1:0] ofs);
    logic [`MCT_ADDR_W-1:0] base;
    base = `MCT_OFF_CH_BASE + `MCT_ADDR_W'(ch * `MCT_CH_STRIDE);
    return base + ofs;
  endfunction

  logic pready_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic blk_en_ff;
  logic updown_ff;
  mct_pkg::count_t count_ff;
  mct_pkg::count_t reload_ff;
  logic dir_down_ff;
  mct_pkg::count_t nxt_count;
  logic nxt_dir_down;
  logic acc_done;
  logic wr_en;
  logic blk_run;
  logic step_down;
  logic at_reload;
  logic [31:0] rd_data;
  logic rd_err;
  logic [7:0] ctrl_arr [`MCT_NUM_CH];
  mct_pkg::count_t cmp_arr [`MCT_NUM_CH];
  logic [`MCT_NUM_CH-1:0] ch_out_w;

  // Completion edge: access phase with ready already high
  assign acc_done = I_PSEL & I_PENABLE & pready_ff;
  assign wr_en = acc_done & I_PWRITE;
  // RQ2: RQ3: stop freezes, nothing reset
  // RQ4: block enable gating
  // RQ1: no halt term, runs while enabled
  assign blk_run = blk_en_ff & ~I_STOP;

  // RQ6: bus path ignores all enables
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= I_PSEL & I_PENABLE & ~pready_ff;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else if (I_PSEL & I_PENABLE & ~pready_ff) begin
      prdata_ff <= I_PWRITE ? 32'h0000_0000 : rd_data;
      pslverr_ff <= rd_err;
    end else begin
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b1;
    if (I_PADDR == `MCT_OFF_BLK_CTRL) begin
      rd_data[`MCT_BLK_EN_BIT] = blk_en_ff;
      rd_data[`MCT_BLK_UPDOWN_BIT] = updown_ff;
      rd_err = 1'b0;
    end else if (I_PADDR == `MCT_OFF_COUNT) begin
      rd_data[`MCT_CNT_W-1:0] = count_ff;
      rd_err = 1'b0;
    end else if (I_PADDR == `MCT_OFF_RELOAD) begin
      rd_data[`MCT_CNT_W-1:0] = reload_ff;
      rd_err = 1'b0;
    end
    for (int c = 0; c < `MCT_NUM_CH; c++) begin
      if (I_PADDR == ch_addr(c, `MCT_CH_CTRL_OFS)) begin
        rd_data[7:0] = ctrl_arr[c];
        rd_err = 1'b0;
      end
      if (I_PADDR == ch_addr(c, `MCT_CH_CMP_OFS)) begin
        rd_data[`MCT_CNT_W-1:0] = cmp_arr[c];
        rd_err = 1'b0;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      blk_en_ff <= 1'b0;
      updown_ff <= 1'b0;
    end else if (wr_en && I_PADDR == `MCT_OFF_BLK_CTRL) begin
      blk_en_ff <= I_PWDATA[`MCT_BLK_EN_BIT];
      updown_ff <= I_PWDATA[`MCT_BLK_UPDOWN_BIT];
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      reload_ff <= `MCT_RST_RELOAD;
    end else if (wr_en && I_PADDR == `MCT_OFF_RELOAD) begin
      reload_ff <= I_PWDATA[`MCT_CNT_W-1:0];
    end
  end

  // Counter step: modulo wraps at reload, up/down bounces
  always_comb begin
    nxt_count = count_ff;
    nxt_dir_down = dir_down_ff;
    if (!updown_ff) begin
      nxt_dir_down = 1'b0;
      nxt_count = (count_ff == reload_ff) ? `MCT_CNT_ZERO : count_ff + `MCT_CNT_ONE;
    end else if (reload_ff == `MCT_CNT_ZERO) begin
      nxt_count = `MCT_CNT_ZERO;
      nxt_dir_down = 1'b0;
    end else if (!dir_down_ff) begin
      if (count_ff >= reload_ff) begin
        nxt_count = count_ff - `MCT_CNT_ONE;
        nxt_dir_down = 1'b1;
      end else begin
        nxt_count = count_ff + `MCT_CNT_ONE;
      end
    end else begin
      if (count_ff == `MCT_CNT_ZERO) begin
        nxt_count = `MCT_CNT_ONE;
        nxt_dir_down = 1'b0;
      end else begin
        nxt_count = count_ff - `MCT_CNT_ONE;
      end
    end
  end

  assign step_down = updown_ff & nxt_dir_down;
  assign at_reload = ~updown_ff & (nxt_count == reload_ff);

  // Software write of the count overrides the running step
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      count_ff <= `MCT_RST_COUNT;
      dir_down_ff <= 1'b0;
    end else if (wr_en && I_PADDR == `MCT_OFF_COUNT) begin
      count_ff <= I_PWDATA[`MCT_CNT_W-1:0];
      dir_down_ff <= 1'b0;
    end else if (blk_run) begin
      count_ff <= nxt_count;
      dir_down_ff <= nxt_dir_down;
    end
  end

  for (genvar g = 0; g < `MCT_NUM_CH; g++) begin : g_ch
    logic [7:0] ctrl_ff;
    mct_pkg::count_t cmp_ff;
    logic out_ff;
    logic in_prev_ff;
    logic ch_run;
    logic cmp_hit;
    logic cap_edge;
    logic pol;
    mct_pkg::method_t meth;

    assign pol = ctrl_ff[`MCT_CH_POL_BIT];
    assign meth = mct_pkg::method_t'(ctrl_ff[`MCT_CH_METH_MSB:`MCT_CH_METH_LSB]);
    // RQ5: per-channel enable gating
    assign ch_run = blk_run & ctrl_ff[`MCT_CH_EN_BIT];
    // Match is taken on the step into the compare value, so it lasts one cycle even if frozen
    assign cmp_hit = ch_run & (nxt_count == cmp_ff);
    // RQ13: edge chosen by polarity
    assign cap_edge = ch_run & (meth == mct_pkg::METH_CAPTURE) &
                      (pol ? (in_prev_ff & ~I_CH_IN[g]) : (~in_prev_ff & I_CH_IN[g]));

    // RQ7: control register, reset zero
    // RQ16: reserved bit masked off
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        ctrl_ff <= `MCT_RST_CH_CTRL;
      end else if (wr_en && I_PADDR == ch_addr(g, `MCT_CH_CTRL_OFS)) begin
        ctrl_ff <= I_PWDATA[7:0] & `MCT_CH_CTRL_WMASK;
      end
    end

    // RQ13: capture latches count, hardware wins over write
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        cmp_ff <= `MCT_RST_CMP;
      end else if (cap_edge) begin
        cmp_ff <= count_ff;
      end else if (wr_en && I_PADDR == ch_addr(g, `MCT_CH_CMP_OFS)) begin
        cmp_ff <= I_PWDATA[`MCT_CNT_W-1:0];
      end
    end

    // Input history frozen in stop so a wake does not see a false edge
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        in_prev_ff <= 1'b0;
      end else if (blk_run) begin
        in_prev_ff <= I_CH_IN[g];
      end
    end

    // Output level per method; whole block frozen while not running
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
      if (I_RST) begin
        out_ff <= 1'b0;
      end else if (blk_run) begin
        unique case (meth)
          mct_pkg::METH_ONE_SHOT: begin
            // RQ8: disabled holds polarity
            // RQ9: one-cycle inverted pulse
            out_ff <= cmp_hit ? ~pol : pol;
          end
          mct_pkg::METH_CONT_CMP: begin
            // RQ8: disabled holds polarity
            if (!ch_run) begin
              out_ff <= pol;
            // RQ10: toggle and hold
            end else if (cmp_hit) begin
              out_ff <= ~out_ff;
            end
          end
          mct_pkg::METH_PWM: begin
            // RQ11: disabled forced low
            if (!ch_run) begin
              out_ff <= 1'b0;
            // RQ12: high on match, low on reload or down-count match
            // RQ14: offset compares in up/down give dead time
            end else if (cmp_hit) begin
              out_ff <= ~step_down;
            end else if (at_reload) begin
              out_ff <= 1'b0;
            end
          end
          mct_pkg::METH_CAPTURE: begin
            out_ff <= 1'b0;
          end
          mct_pkg::METH_IDLE4, mct_pkg::METH_IDLE5, mct_pkg::METH_IDLE6, mct_pkg::METH_IDLE7: begin
            // RQ15: unassigned codes idle at polarity
            out_ff <= pol;
          end
        endcase
      end
    end

    assign ctrl_arr[g] = ctrl_ff;
    assign cmp_arr[g] = cmp_ff;
    assign ch_out_w[g] = out_ff;
  end

  assign O_PRDATA = prdata_ff;
  assign O_PREADY = pready_ff;
  assign O_PSLVERR = pslverr_ff;
  assign O_CH_OUT = ch_out_w;

endmodule

// [mct_map.svh]
// Register offsets, field positions and reset values of the multi-channel timer
`ifndef MCT_MAP_SVH
`define MCT_MAP_SVH

`define MCT_NUM_CH 4
`define MCT_ADDR_W 8
`define MCT_CNT_W 16

`define MCT_OFF_BLK_CTRL 8'h00
`define MCT_OFF_COUNT 8'h04
`define MCT_OFF_RELOAD 8'h08
`define MCT_OFF_CH_BASE 8'h10
`define MCT_CH_STRIDE 8'h08
`define MCT_CH_CMP_OFS 8'h04
`define MCT_CH_CTRL_OFS 8'h00

`define MCT_BLK_EN_BIT 0
`define MCT_BLK_UPDOWN_BIT 1

`define MCT_CH_EN_BIT 7
`define MCT_CH_POL_BIT 6
`define MCT_CH_IEN_BIT 5
`define MCT_CH_AUX_BIT 4
`define MCT_CH_RSVD_BIT 3
`define MCT_CH_METH_MSB 2
`define MCT_CH_METH_LSB 0
`define MCT_CH_CTRL_WMASK 8'hF7

`define MCT_RST_CH_CTRL 8'h00
`define MCT_RST_COUNT 16'h0000
`define MCT_RST_RELOAD 16'hFFFF
`define MCT_RST_CMP 16'h0000
`define MCT_CNT_ZERO 16'h0000
`define MCT_CNT_ONE 16'h0001

`endif

// [mct_pkg.sv]
// Types shared by the multi-channel timer
package mct_pkg;
  typedef enum logic [2:0] {
    METH_ONE_SHOT = 3'h0,
    METH_CONT_CMP = 3'h1,
    METH_PWM = 3'h2,
    METH_CAPTURE = 3'h3,
    METH_IDLE4 = 3'h4,
    METH_IDLE5 = 3'h5,
    METH_IDLE6 = 3'h6,
    METH_IDLE7 = 3'h7
  } method_t;
  typedef logic [15:0] count_t;
endpackage

// [mct_timer_props.sv]
// Port-level checks for the multi-channel timer
`timescale 1ns/100ps
`include "mct_map.svh"
module mct_timer_chk (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_STOP,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [`MCT_ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  input wire logic [`MCT_NUM_CH-1:0] I_CH_IN,
  input wire logic [`MCT_NUM_CH-1:0] O_CH_OUT
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  a_ready_two_cycles: assert property ($rose(I_PENABLE) && I_PSEL |-> !O_PREADY ##1 O_PREADY)
    else $error("access phase not two cycles");
  a_ready_one_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_ready_has_cause: assert property (O_PREADY |-> $past(I_PSEL && I_PENABLE))
    else $error("ready without access");
  a_idle_data_zero: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
    else $error("read data outside answer");
  a_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  a_unmapped_err: assert property (O_PREADY && I_PADDR == 8'h0C |-> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access not refused");
  a_ctrl_rsvd_zero: assert property (O_PREADY && !I_PWRITE && I_PADDR == 8'h10 |-> !O_PSLVERR && O_PRDATA[3] == 1'b0)
    else $error("reserved control bit reads set");
  a_stop_holds_out: assert property ($past(I_STOP) |-> O_CH_OUT == $past(O_CH_OUT))
    else $error("outputs moved in stop mode");
  c_unmapped: cover property (O_PSLVERR);
  c_out_rise: cover property ($rose(O_CH_OUT[0]));
  c_stop_run: cover property (I_STOP ##1 !I_STOP);
endmodule
bind mct_timer mct_timer_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_STOP(I_STOP), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_CH_IN(I_CH_IN), .O_CH_OUT(O_CH_OUT));

// [pin_src.sv]
// Pin-side source of capture edges
`timescale 1ns/100ps
module pin_src (
  input wire logic i_clk,
  input wire logic [3:0] i_level,
  output logic [3:0] o_pin
);
  // Synchronous source: pins move only just after an edge
  always_ff @(posedge i_clk) begin
    o_pin <= i_level;
  end
endmodule

// [testbench.sv]
// Self-checking bench for the multi-channel timer
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rst = 1, stop = 0, psel = 0, pen = 0, pwr = 0, err, pready, perr;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rd, prdata;
  logic [3:0] lvl = 4'h0, pin, chout, prev;
  int n_fail = 0, cmp_count = 0, seed = 42011, cyc = 0, hi, pw, tg, dz, a, mdl[int];
  int ctl[4] = '{32'h40, 32'h42, 32'h00, 32'h03};
  int cv[4] = '{10, 10, 5, 32'hABCD};
  always #2 clk = ~clk;
  mct_timer dut (.I_REF_CLK(clk), .I_RST(rst), .I_STOP(stop), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(addr), .I_PWDATA(wdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(perr), .I_CH_IN(pin),
    .O_CH_OUT(chout));
  pin_src src (.i_clk(clk), .i_level(lvl), .o_pin(pin));
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Request held until ready is seen at a rising edge; answer taken there
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    addr <= ad;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
    mdl[ad] = (ad >= 8'h10 && !ad[2]) ? d & 32'hF7 : d & 32'hFFFF;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    mdl[8] = 32'hFFFF;
    for (a = 0; a < 4; a++) begin
      mdl[16 + 8 * a] = 0;
      mdl[20 + 8 * a] = 0;
    end
    for (a = 0; a < 10; a++) begin
      if (a > 1) wr(8'h10 + 8'(4 * ($random(seed) & 7)), $random(seed));
      foreach (mdl[k]) begin
        bus(1'b0, 8'(k), 32'h0);
        chk(rd, mdl[k]);
        chk(err, 1'b0);
      end
    end
    $display("test registers done");
    bus(1'b1, 8'h0C, 32'h5A5A);
    chk(err, 1'b1);
    bus(1'b0, 8'h0C, 32'h0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    $display("test unmapped done");
    wr(8'h08, 20);
    for (a = 0; a < 4; a++) begin
      wr(8'h10 + 8'(8 * a), ctl[a]);
      wr(8'h14 + 8'(8 * a), cv[a]);
    end
    wr(8'h00, 1);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk(chout, 4'b0001);
    $display("test idle levels done");
    wr(8'h10, 8'h80);
    wr(8'h18, 8'h82);
    wr(8'h20, 8'h81);
    // PWM only settles after its first match
    repeat (21) @(posedge clk);
    hi = 0;
    pw = 0;
    tg = 0;
    prev = chout;
    repeat (42) begin
      @(negedge clk);
      hi += chout[0];
      pw += chout[1];
      tg += (chout[2] != prev[2]);
      prev = chout;
    end
    chk(hi, 2);
    chk(pw, 20);
    chk(tg, 2);
    $display("test compare outputs done");
    // Toggle the pin under both polarities; only the chosen edge may capture
    for (a = 0; a < 4; a++) begin
      wr(8'h28, a < 2 ? 8'h83 : 8'hC3);
      wr(8'h2C, 16'hABCD);
      lvl[3] <= ~lvl[3];
      repeat (4) @(posedge clk);
      bus(1'b0, 8'h2C, 32'h0);
      chk(rd <= 20, a == 0 || a == 3);
    end
    $display("test capture done");
    for (a = 0; a < 2; a++) begin
      if (a == 0) stop <= 1'b1;
      else wr(8'h00, 0);
      bus(1'b0, 8'h04, 32'h0);
      hi = rd;
      repeat (5) @(posedge clk);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd, hi);
      stop <= 1'b0;
      wr(8'h00, 1);
      bus(1'b0, 8'h04, 32'h0);
      chk(rd != hi, 1'b1);
    end
    $display("test freeze done");
    // Up/down: two PWM channels, compares 12 and 10, reload 20
    wr(8'h10, 8'h82);
    wr(8'h14, 12);
    wr(8'h00, 3);
    repeat (40) @(posedge clk);
    hi = 0;
    pw = 0;
    tg = 0;
    dz = 0;
    repeat (80) begin
      @(negedge clk);
      hi += chout[0];
      pw += chout[1];
      tg += chout[0] & ~chout[1];
      dz += chout[1] & ~chout[0];
    end
    chk(pw, 40);
    chk(hi, 32);
    chk(tg, 0);
    chk(dz, 8);
    $display("test up/down done");
    wrap_up();
  end
endmodule
